// ---- include/ttu_pkg.sv ----
package ttu_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int          NUM_TIMERS = 3;
    localparam int          NUM_PINNED = 2;
    localparam int          CNT_W      = 16;
    localparam int          ADDR_W     = 8;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  T0_COUNT_OFS = 8'h50;
    localparam logic [7:0]  T0_LIMA_OFS  = 8'h52;
    localparam logic [7:0]  T0_LIMB_OFS  = 8'h54;
    localparam logic [7:0]  T0_CTRL_OFS  = 8'h56;
    localparam logic [7:0]  T1_COUNT_OFS = 8'h58;
    localparam logic [7:0]  T1_LIMA_OFS  = 8'h5A;
    localparam logic [7:0]  T1_LIMB_OFS  = 8'h5C;
    localparam logic [7:0]  T1_CTRL_OFS  = 8'h5E;
    localparam logic [7:0]  T2_COUNT_OFS = 8'h60;
    localparam logic [7:0]  T2_LIMA_OFS  = 8'h62;
    localparam logic [7:0]  T2_CTRL_OFS  = 8'h66;
    localparam logic [7:0]  NO_REG_OFS   = 8'hFF;

    // ------------------------------------------------------------
    // register kinds within one timer
    // ------------------------------------------------------------
    localparam logic [1:0]  KIND_COUNT = 2'h0;
    localparam logic [1:0]  KIND_LIMA  = 2'h1;
    localparam logic [1:0]  KIND_LIMB  = 2'h2;
    localparam logic [1:0]  KIND_CTRL  = 2'h3;

    // ------------------------------------------------------------
    // control word field positions
    // ------------------------------------------------------------
    localparam int          RUN_BIT   = 15;
    localparam int          MASK_BIT  = 14;
    localparam int          IRQ_BIT   = 13;
    localparam int          AFLAG_BIT = 12;
    localparam int          HIT_BIT   = 5;
    localparam int          RTG_BIT   = 4;
    localparam int          PRE_BIT   = 3;
    localparam int          EXT_BIT   = 2;
    localparam int          TWO_BIT   = 1;
    localparam int          FREE_BIT  = 0;

    // ------------------------------------------------------------
    // service slots
    // ------------------------------------------------------------
    localparam logic [1:0]  SLOT_LAST = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic run_gate;
        logic irq_on_limit;
        logic active_limit_flag;
        logic limit_hit_flag;
        logic input_restart;
        logic timer2_clock_source;
        logic outside_clock_select;
        logic two_limit_mode;
        logic free_running;
    } ttu_ctrl_t;

    typedef struct packed {
        logic                 valid;
        logic [ADDR_W-1:0]    addr;
        logic [CNT_W-1:0]     data;
    } ttu_wreq_t;

    typedef enum logic {
        RT_WAIT = 1'b0,
        RT_RUN  = 1'b1
    } ttu_rtg_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam ttu_ctrl_t   CTRL_RST_PINNED = 9'b0_0_0_0_0_0_0_1_0;
    localparam ttu_ctrl_t   CTRL_RST_T2     = 9'b0_0_0_0_0_0_0_0_0;
    localparam logic [15:0] RDATA_RST       = 16'h0000;

endpackage

// ---- hw/ttu_timers.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module ttu_timers (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [15:0] bus_rdata,
    input  wire logic [1:0]  tmr_in,
    output logic      [1:0]  tmr_out,
    output logic      [2:0]  irq_req
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ttu_pkg::ttu_ctrl_t ctrl_q   [ttu_pkg::NUM_TIMERS];
    ttu_pkg::ttu_ctrl_t ctrl_d   [ttu_pkg::NUM_TIMERS];
    logic [15:0]        count_q  [ttu_pkg::NUM_TIMERS];
    logic [15:0]        count_d  [ttu_pkg::NUM_TIMERS];
    logic [15:0]        lima_q   [ttu_pkg::NUM_TIMERS];
    logic [15:0]        limb_q   [ttu_pkg::NUM_PINNED];
    ttu_pkg::ttu_rtg_t  rtg_q    [ttu_pkg::NUM_PINNED];
    ttu_pkg::ttu_rtg_t  rtg_d    [ttu_pkg::NUM_PINNED];
    logic [2:0]         hit_d;
    logic [2:0]         hit_q;
    logic [2:0]         count_wr;
    logic [1:0]         slot_q;
    logic [1:0]         in_s1_q;
    logic [1:0]         in_s2_q;
    logic [1:0]         in_s3_q;
    logic [1:0]         edge_q;
    logic [1:0]         edge_d;
    logic [1:0]         pre_q;
    logic [1:0]         pre_d;
    ttu_pkg::ttu_wreq_t wreq_q;
    logic [15:0]        rdata_q;
    logic [1:0]         tout_q;
    logic [2:0]         irq_q;

    assign bus_rdata = rdata_q;
    assign tmr_out   = tout_q;
    assign irq_req   = irq_q;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_ofs(input int t, input logic [1:0] k);
        logic [7:0] r;
        r = ttu_pkg::NO_REG_OFS;
        case ({t[1:0], k})
            4'h0: r = ttu_pkg::T0_COUNT_OFS;
            4'h1: r = ttu_pkg::T0_LIMA_OFS;
            4'h2: r = ttu_pkg::T0_LIMB_OFS;
            4'h3: r = ttu_pkg::T0_CTRL_OFS;
            4'h4: r = ttu_pkg::T1_COUNT_OFS;
            4'h5: r = ttu_pkg::T1_LIMA_OFS;
            4'h6: r = ttu_pkg::T1_LIMB_OFS;
            4'h7: r = ttu_pkg::T1_CTRL_OFS;
            4'h8: r = ttu_pkg::T2_COUNT_OFS;
            4'h9: r = ttu_pkg::T2_LIMA_OFS;
            4'hB: r = ttu_pkg::T2_CTRL_OFS;
            default: r = ttu_pkg::NO_REG_OFS;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] ctrl_word(input ttu_pkg::ttu_ctrl_t c);
        logic [15:0] w;
        w = 16'h0000;
        w[ttu_pkg::RUN_BIT]   = c.run_gate;
        w[ttu_pkg::IRQ_BIT]   = c.irq_on_limit;
        w[ttu_pkg::AFLAG_BIT] = c.active_limit_flag;
        w[ttu_pkg::HIT_BIT]   = c.limit_hit_flag;
        w[ttu_pkg::RTG_BIT]   = c.input_restart;
        w[ttu_pkg::PRE_BIT]   = c.timer2_clock_source;
        w[ttu_pkg::EXT_BIT]   = c.outside_clock_select;
        w[ttu_pkg::TWO_BIT]   = c.two_limit_mode;
        w[ttu_pkg::FREE_BIT]  = c.free_running;
        return w;
    endfunction

    // ------------------------------------------------------------
    // service slot and pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            slot_q <= 2'h0;
        end else begin
            slot_q <= (slot_q == ttu_pkg::SLOT_LAST) ? 2'h0 : slot_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            in_s1_q <= 2'h0;
            in_s2_q <= 2'h0;
            in_s3_q <= 2'h0;
        end else begin
            in_s1_q <= tmr_in;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end

    // ------------------------------------------------------------
    // write wait stage
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wreq_q <= '0;
        end else begin
            wreq_q.valid <= bus_wr;
            wreq_q.addr  <= bus_addr;
            wreq_q.data  <= bus_wdata;
        end
    end

    // ------------------------------------------------------------
    // timer next state
    // ------------------------------------------------------------
    always_comb begin
        logic        serve;
        logic        edg;
        logic        tick;
        logic        gate;
        logic        pin_hi;
        logic [15:0] lim;
        logic [15:0] inc;
        logic [15:0] wd;
        ttu_pkg::ttu_ctrl_t c;
        serve = 1'b0;
        edg = 1'b0;
        tick = 1'b0;
        gate = 1'b0;
        pin_hi = 1'b0;
        lim = 16'h0000;
        inc = 16'h0000;
        wd = wreq_q.data;
        c = ctrl_q[0];
        pre_d = pre_q;
        for (int j = 0; j < ttu_pkg::NUM_PINNED; j++) begin
            rtg_d[j]  = rtg_q[j];
            edge_d[j] = 1'b0;
        end
        for (int i = 0; i < ttu_pkg::NUM_TIMERS; i++) begin
            c = ctrl_q[i];
            serve = (slot_q == i[1:0]);
            hit_d[i] = 1'b0;
            count_d[i] = count_q[i];
            lim = (c.two_limit_mode && c.active_limit_flag && i < 2)
                ? limb_q[i[0]] : lima_q[i];
            inc = count_q[i] + 16'h0001;
            if (i < 2) begin
                pin_hi = in_s2_q[i];
                edg = edge_q[i] | (in_s2_q[i] & ~in_s3_q[i]);
                edge_d[i] = c.run_gate & edg & ~serve;
                tick = c.outside_clock_select ? edg
                     : (c.timer2_clock_source ? pre_q[i] : 1'b1);
                gate = c.outside_clock_select ? 1'b1
                     : (c.input_restart ? (rtg_q[i] == ttu_pkg::RT_RUN) : pin_hi);
                if (serve) begin
                    pre_d[i] = 1'b0;
                end
                if (!c.run_gate) begin
                    rtg_d[i] = ttu_pkg::RT_WAIT;
                end
            end else begin
                tick = 1'b1;
                gate = 1'b1;
                edg = 1'b0;
            end
            if (serve && c.run_gate) begin
                if (i < 2 && !c.outside_clock_select && c.input_restart && edg) begin
                    count_d[i] = 16'h0000;
                    rtg_d[i[0]] = ttu_pkg::RT_RUN;
                end else if (tick && gate) begin
                    if (inc == lim) begin
                        count_d[i] = 16'h0000;
                        hit_d[i] = 1'b1;
                    end else begin
                        count_d[i] = inc;
                    end
                end
            end
            if (hit_d[i]) begin
                c.limit_hit_flag = 1'b1;
                if (c.two_limit_mode) begin
                    c.active_limit_flag = ~c.active_limit_flag;
                end
                if (!c.free_running && (!c.two_limit_mode || ctrl_q[i].active_limit_flag)) begin
                    c.run_gate = 1'b0;
                end
            end
            if (wreq_q.valid && wreq_q.addr == reg_ofs(i, ttu_pkg::KIND_CTRL)) begin
                if (wd[ttu_pkg::MASK_BIT]) begin
                    c.run_gate = wd[ttu_pkg::RUN_BIT];
                end
                c.irq_on_limit         = wd[ttu_pkg::IRQ_BIT];
                c.limit_hit_flag       = hit_d[i] | wd[ttu_pkg::HIT_BIT];
                c.input_restart        = wd[ttu_pkg::RTG_BIT];
                c.timer2_clock_source  = wd[ttu_pkg::PRE_BIT];
                c.outside_clock_select = wd[ttu_pkg::EXT_BIT];
                c.two_limit_mode       = wd[ttu_pkg::TWO_BIT];
                c.free_running         = wd[ttu_pkg::FREE_BIT];
            end
            if (!c.two_limit_mode) begin
                c.active_limit_flag = 1'b0;
            end
            if (i == 2) begin
                c.two_limit_mode       = 1'b0;
                c.outside_clock_select = 1'b0;
                c.timer2_clock_source  = 1'b0;
                c.input_restart        = 1'b0;
                c.active_limit_flag    = 1'b0;
            end
            ctrl_d[i] = c;
            count_wr[i] = wreq_q.valid && wreq_q.addr == reg_ofs(i, ttu_pkg::KIND_COUNT);
            if (count_wr[i]) begin
                count_d[i] = wd;
            end
        end
        if (hit_d[2]) begin
            pre_d = 2'h3;
        end
    end

    // ------------------------------------------------------------
    // timer registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_q[0] <= ttu_pkg::CTRL_RST_PINNED;
            ctrl_q[1] <= ttu_pkg::CTRL_RST_PINNED;
            ctrl_q[2] <= ttu_pkg::CTRL_RST_T2;
            rtg_q[0]  <= ttu_pkg::RT_WAIT;
            rtg_q[1]  <= ttu_pkg::RT_WAIT;
            edge_q    <= 2'h0;
            pre_q     <= 2'h0;
            hit_q     <= 3'h0;
        end else begin
            for (int i = 0; i < ttu_pkg::NUM_TIMERS; i++) begin
                ctrl_q[i] <= ctrl_d[i];
            end
            rtg_q[0] <= rtg_d[0];
            rtg_q[1] <= rtg_d[1];
            edge_q   <= edge_d;
            pre_q    <= pre_d;
            hit_q    <= hit_d;
        end
    end

    // count and limits carry no reset; software loads them
    always_ff @(posedge clock) begin
        for (int i = 0; i < ttu_pkg::NUM_TIMERS; i++) begin
            count_q[i] <= count_d[i];
            if (wreq_q.valid && wreq_q.addr == reg_ofs(i, ttu_pkg::KIND_LIMA)) begin
                lima_q[i] <= wreq_q.data;
            end
        end
        for (int j = 0; j < ttu_pkg::NUM_PINNED; j++) begin
            if (wreq_q.valid && wreq_q.addr == reg_ofs(j, ttu_pkg::KIND_LIMB)) begin
                limb_q[j] <= wreq_q.data;
            end
        end
    end

    // ------------------------------------------------------------
    // pins and interrupt requests
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tout_q <= 2'h3;
        end else begin
            for (int j = 0; j < ttu_pkg::NUM_PINNED; j++) begin
                tout_q[j] <= ctrl_q[j].two_limit_mode ? ~ctrl_q[j].active_limit_flag
                           : ~hit_q[j];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 3'h0;
        end else begin
            for (int i = 0; i < ttu_pkg::NUM_TIMERS; i++) begin
                irq_q[i] <= hit_d[i] & ctrl_q[i].irq_on_limit;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= ttu_pkg::RDATA_RST;
        end else begin
            rdata_q <= 16'h0000;
            if (bus_rd) begin
                for (int i = 0; i < ttu_pkg::NUM_TIMERS; i++) begin
                    if (bus_addr == reg_ofs(i, ttu_pkg::KIND_COUNT)) begin
                        rdata_q <= count_q[i];
                    end
                    if (bus_addr == reg_ofs(i, ttu_pkg::KIND_LIMA)) begin
                        rdata_q <= lima_q[i];
                    end
                    if (bus_addr == reg_ofs(i, ttu_pkg::KIND_CTRL)) begin
                        rdata_q <= ctrl_word(ctrl_q[i]);
                    end
                end
                for (int j = 0; j < ttu_pkg::NUM_PINNED; j++) begin
                    if (bus_addr == reg_ofs(j, ttu_pkg::KIND_LIMB)) begin
                        rdata_q <= limb_q[j];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_count_zero_hit: assert property (hit_q[0] && !$past(count_wr[0]) |-> count_q[0] == 16'h0000)
        else $error("count not zero after limit match");
    a_pulse_one_low: assert property (hit_q[0] && !ctrl_q[0].two_limit_mode
        |=> !tmr_out[0] ##1 (tmr_out[0] || ctrl_q[0].two_limit_mode || hit_q[0]))
        else $error("single limit pulse wrong");
    a_out_shows_limit: assert property (ctrl_q[1].two_limit_mode && $past(ctrl_q[1].two_limit_mode)
        |-> tmr_out[1] == !$past(ctrl_q[1].active_limit_flag))
        else $error("output does not show limit in use");
    a_limit_alternates: assert property (hit_d[0] && ctrl_q[0].two_limit_mode && !count_wr[0]
        && !(wreq_q.valid && wreq_q.addr == ttu_pkg::T0_CTRL_OFS)
        |=> ctrl_q[0].active_limit_flag != $past(ctrl_q[0].active_limit_flag))
        else $error("limit did not alternate");
    a_flag_held_zero: assert property (!ctrl_q[1].two_limit_mode |-> !ctrl_q[1].active_limit_flag)
        else $error("limit flag set without two limit mode");
    a_service_slot: assert property (count_q[0] != $past(count_q[0])
        |-> $past(slot_q) == 2'h0 || $past(count_wr[0]))
        else $error("timer advanced outside its slot");
    a_write_wait: assert property (bus_wr |=> wreq_q.valid && wreq_q.addr == $past(bus_addr))
        else $error("write not staged");
    a_halt_holds: assert property (!ctrl_q[1].run_gate && !count_wr[1] |=> $stable(count_q[1]))
        else $error("count moved while halted");
    a_oneshot_halt: assert property (hit_d[2] && !ctrl_q[2].free_running
        && !(wreq_q.valid && wreq_q.addr == ttu_pkg::T2_CTRL_OFS) |=> !ctrl_q[2].run_gate)
        else $error("one shot did not halt");
    a_mask_reads_zero: assert property (bus_rd && bus_addr == ttu_pkg::T0_CTRL_OFS
        |=> !bus_rdata[ttu_pkg::MASK_BIT] && bus_rdata[11:6] == 6'h00)
        else $error("mask or unused bits read nonzero");
    a_irq_on_hit: assert property (hit_d[1] && ctrl_q[1].irq_on_limit |=> irq_req[1])
        else $error("interrupt request missing");
    a_hit_sticky: assert property (ctrl_q[0].limit_hit_flag
        && !(wreq_q.valid && wreq_q.addr == ttu_pkg::T0_CTRL_OFS) |=> ctrl_q[0].limit_hit_flag)
        else $error("hit flag dropped");
    a_t2_fixed_bits: assert property (!ctrl_q[2].two_limit_mode && !ctrl_q[2].outside_clock_select
        && !ctrl_q[2].input_restart && !ctrl_q[2].active_limit_flag)
        else $error("timer two mode bits not fixed");

    c_alt_hit: cover property (hit_q[0] && ctrl_q[0].two_limit_mode);
    c_restart: cover property (rtg_q[0] == ttu_pkg::RT_RUN ##1 count_q[0] == 16'h0000);
    c_prescale: cover property (hit_q[2] ##[1:8] hit_q[1]);
    c_ext_count: cover property (ctrl_q[1].outside_clock_select && hit_q[1]);

endmodule

// ---- verif/ttu_pin_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// far side: input pins driven, output pins watched
// ------------------------------------------------------------
module ttu_pin_model (
    input  wire logic       clock,
    input  wire logic [1:0] level,
    input  wire logic       clr,
    input  wire logic [1:0] tmr_out,
    output logic      [1:0] tmr_in,
    output logic      [7:0] low0,
    output logic      [7:0] low1
);
    always @(posedge clock) begin
        tmr_in <= level;
        low0   <= clr ? 8'h00 : low0 + 8'(tmr_out[0] === 1'b0);
        low1   <= clr ? 8'h00 : low1 + 8'(tmr_out[1] === 1'b0);
    end
endmodule

// ---- verif/triple_timer_unit_bench.sv ----
`timescale 1ns/10ps
module triple_timer_unit_bench;
    logic        clock;
    logic        rstn;
    logic        bus_wr;
    logic        bus_rd;
    logic        clr;
    logic [7:0]  bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic [15:0] v;
    logic [1:0]  tmr_in;
    logic [1:0]  tmr_out;
    logic [1:0]  level;
    logic [2:0]  irq_req;
    logic [7:0]  low0;
    logic [7:0]  low1;
    int          fail_count;
    int          n_tests;
    int          irq0;
    int          irq_hi;

    ttu_timers i_ttu_timers (.clock(clock), .rstn(rstn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .tmr_in(tmr_in), .tmr_out(tmr_out), .irq_req(irq_req));
    ttu_pin_model i_ttu_pin_model (.clock(clock), .level(level), .clr(clr),
        .tmr_out(tmr_out), .tmr_in(tmr_in), .low0(low0), .low1(low1));

    // ------------------------------------------------------------
    // clock, bus tasks, checks
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) irq0 <= clr ? 0 : irq0 + int'(irq_req[0] === 1'b1);
    always @(posedge clock) irq_hi <= clr ? 0 : irq_hi + int'(irq_req[1] === 1'b1)
        + int'(irq_req[2] === 1'b1);

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clock);
        bus_wr    <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clock);
        bus_rd   <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("pins", {14'h0, tmr_out}, 16'h0003);
        rd(ttu_pkg::T0_CTRL_OFS, v);
        chk("t0 ctrl", v, 16'h0002);
        rd(ttu_pkg::T2_CTRL_OFS, v);
        chk("t2 ctrl", v, 16'h0000);
        rd(8'h64, v);
        chk("no limb t2", v, 16'h0000);
        wr(ttu_pkg::T2_CTRL_OFS, 16'hC01E);
        rd(ttu_pkg::T2_CTRL_OFS, v);
        chk("t2 fixed", v, 16'h8000);
        wr(ttu_pkg::T2_CTRL_OFS, 16'h4000);
    endtask
    task automatic t_single;
        level = 2'h0;
        wr(ttu_pkg::T0_LIMA_OFS, 16'h0003);
        wr(ttu_pkg::T0_CTRL_OFS, 16'hE001);
        wr(ttu_pkg::T0_COUNT_OFS, 16'h0005);
        repeat (20) @(posedge clock);
        rd(ttu_pkg::T0_COUNT_OFS, v);
        chk("gated hold", v, 16'h0005);
        wr(ttu_pkg::T0_COUNT_OFS, 16'h0000);
        clr   <= 1'b1;
        level <= 2'h1;
        @(posedge clock);
        clr <= 1'b0;
        repeat (100) @(posedge clock);
        level <= 2'h0;
        repeat (12) @(posedge clock);
        chk("irq seen", 16'(irq0 > 6), 16'h0001);
        chk("low clocks", {8'h0, low0}, 16'(irq0));
        rd(ttu_pkg::T0_CTRL_OFS, v);
        chk("t0 hit", v, 16'hA021);
        wr(ttu_pkg::T0_CTRL_OFS, 16'h4000);
    endtask
    task automatic t_oneshot;
        wr(ttu_pkg::T1_LIMA_OFS, 16'h0002);
        wr(ttu_pkg::T1_LIMB_OFS, 16'h0003);
        wr(ttu_pkg::T1_COUNT_OFS, 16'h0000);
        clr   <= 1'b1;
        level <= 2'h2;
        @(posedge clock);
        clr <= 1'b0;
        wr(ttu_pkg::T1_CTRL_OFS, 16'hC002);
        repeat (80) @(posedge clock);
        chk("b phase", {8'h0, low1}, 16'h000C);
        rd(ttu_pkg::T1_CTRL_OFS, v);
        chk("halted", v, 16'h0022);
        rd(ttu_pkg::T1_COUNT_OFS, v);
        chk("t1 count", v, 16'h0000);
        wr(ttu_pkg::T1_CTRL_OFS, 16'h9FC2);
        rd(ttu_pkg::T1_CTRL_OFS, v);
        chk("masked", v, 16'h0002);
    endtask
    task automatic pulses(input logic [1:0] m, input int n);
        repeat (n) begin
            level <= m;
            repeat (4) @(posedge clock);
            level <= 2'h0;
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic t_ext;
        wr(ttu_pkg::T1_COUNT_OFS, 16'h0000);
        wr(ttu_pkg::T1_LIMA_OFS, 16'h0003);
        wr(ttu_pkg::T1_CTRL_OFS, 16'h6005);
        pulses(2'h2, 3);
        rd(ttu_pkg::T1_COUNT_OFS, v);
        chk("halted pin", v, 16'h0000);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wr(ttu_pkg::T1_CTRL_OFS, 16'hE005);
        pulses(2'h2, 5);
        rd(ttu_pkg::T1_COUNT_OFS, v);
        chk("ext count", v, 16'h0002);
        chk("ext irq", 16'(irq_hi), 16'h0001);
        chk("ext pulse", {8'h0, low1}, 16'h0001);
        rd(ttu_pkg::T1_CTRL_OFS, v);
        chk("ext ctrl", v, 16'hA025);
    endtask
    task automatic t_prescale;
        wr(ttu_pkg::T0_COUNT_OFS, 16'h0000);
        wr(ttu_pkg::T0_LIMA_OFS, 16'h0100);
        level <= 2'h1;
        wr(ttu_pkg::T0_CTRL_OFS, 16'hC009);
        repeat (20) @(posedge clock);
        rd(ttu_pkg::T0_COUNT_OFS, v);
        chk("no prescale tick", v, 16'h0000);
        wr(ttu_pkg::T2_COUNT_OFS, 16'h0000);
        wr(ttu_pkg::T2_LIMA_OFS, 16'h0002);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wr(ttu_pkg::T2_CTRL_OFS, 16'hE001);
        repeat (40) @(posedge clock);
        wr(ttu_pkg::T2_CTRL_OFS, 16'h4000);
        repeat (4) @(posedge clock);
        rd(ttu_pkg::T0_COUNT_OFS, v);
        chk("prescaled count", v, 16'(irq_hi));
        chk("t2 irq", 16'(irq_hi > 3), 16'h0001);
    endtask
    task automatic t_restart;
        level <= 2'h0;
        wr(ttu_pkg::T0_COUNT_OFS, 16'h0050);
        wr(ttu_pkg::T0_CTRL_OFS, 16'hC011);
        repeat (12) @(posedge clock);
        rd(ttu_pkg::T0_COUNT_OFS, v);
        chk("restart wait", v, 16'h0050);
        repeat (2) begin
            level <= 2'h1;
            repeat (8) @(posedge clock);
            rd(ttu_pkg::T0_COUNT_OFS, v);
            chk("restart clear", 16'(v < 16'h0004), 16'h0001);
            repeat (40) @(posedge clock);
            level <= 2'h0;
            repeat (4) @(posedge clock);
        end
    endtask

    initial begin
        rstn = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        clr = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 16'h0000;
        level = 2'h0;
        fail_count = 0;
        n_tests = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_single();
        t_oneshot();
        t_ext();
        t_prescale();
        t_restart();
        wrap_up();
    end
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end
endmodule
